// >>> design/crtc_addr_pkg.sv
// Constants, register map and carrier types for the display refresh address generator
package crtc_addr_pkg;

  // ---------------------------------------------------------------
  // Host I/O ports of the indexed register file
  // ---------------------------------------------------------------
  localparam logic [15:0] IO_INDEX_MONO = 16'h03B4;
  localparam logic [15:0] IO_DATA_MONO  = 16'h03B5;
  localparam logic [15:0] IO_INDEX_COLR = 16'h03D4;
  localparam logic [15:0] IO_DATA_COLR  = 16'h03D5;

  // ---------------------------------------------------------------
  // Register indices
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_OVERFLOW   = 8'h07;
  localparam logic [7:0] IDX_MAX_SCAN   = 8'h09;
  localparam logic [7:0] IDX_START_HIGH = 8'h0C;
  localparam logic [7:0] IDX_START_LOW  = 8'h0D;
  localparam logic [7:0] IDX_UNDERLINE  = 8'h14;
  localparam logic [7:0] IDX_MODE_CTRL  = 8'h17;
  localparam logic [7:0] IDX_LINE_CMP   = 8'h18;
  localparam logic [7:0] IDX_LATCH_VIEW = 8'h22;
  localparam logic [7:0] IDX_TOGGLE_VW  = 8'h24;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int OVF_LINE_CMP_BIT  = 4;
  localparam int MSL_LINE_CMP_BIT  = 6;
  localparam int TOGGLE_BIT        = 7;
  localparam logic [7:0] MODE_RSVD_MASK  = 8'hEF;
  localparam logic [7:0] UNDER_RSVD_MASK = 8'h7F;
  localparam logic [7:0] REG_RESET       = 8'h00;
  localparam logic [7:0] VIEW_RESET      = 8'h00;
  localparam logic       SYNC_INACTIVE   = 1'b0;

  // Tick divider ratios, as log2 of the interval
  localparam logic [1:0] DIV_BY_1 = 2'h0;
  localparam logic [1:0] DIV_BY_2 = 2'h1;
  localparam logic [1:0] DIV_BY_4 = 2'h2;

  // ---------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic sync_en;
    logic word_byte;
    logic addr_wrap;
    logic rsvd;
    logic count_by_2;
    logic retrace_div;
    logic row_scan_sel;
    logic compat;
  } refresh_mode_t;

  typedef struct packed {
    logic       rsvd;
    logic       dword;
    logic       count_by_4;
    logic [4:0] underline_row;
  } underline_t;

  typedef enum logic [1:0] {
    ADDR_BYTE,
    ADDR_WORD,
    ADDR_DWORD
  } addr_mode_t;

endpackage

// >>> design/tick_divider.sv
// Pulse divider that passes every first, second or fourth input tick
`timescale 1ns/1ps
module tick_divider
  import crtc_addr_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  input  wire logic       align_i,
  input  wire logic       tick_i,
  input  wire logic [1:0] ratio_i,
  output logic            tick_o
);

  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic [1:0] last_w;
  logic       wrap_w;

  // Ratio encodes log2 of the interval
  assign last_w = (ratio_i == DIV_BY_4) ? 2'h3 : ((ratio_i == DIV_BY_2) ? 2'h1 : 2'h0);
  assign wrap_w = (cnt_q >= last_w);
  assign tick_o = tick_i && wrap_w && !align_i;
  assign cnt_d  = align_i ? 2'h0 : (tick_i ? (wrap_w ? 2'h0 : cnt_q + 2'h1) : cnt_q);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q <= 2'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule

// >>> design/vga_crtc_address_generator.sv
// Refresh address generator with indexed host registers, split screen and sync gating
`timescale 1ns/1ps
module vga_crtc_address_generator
  import crtc_addr_pkg::*;
#(
  parameter int LINE_W = 10
)
(
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        color_sel_i,
  input  wire logic [15:0] io_addr_i,
  input  wire logic        io_wr_i,
  input  wire logic        io_rd_i,
  input  wire logic [7:0]  io_wdata_i,
  output logic      [7:0]  io_rdata_o,
  output logic             io_rvalid_o,
  input  wire logic        char_tick_i,
  input  wire logic        hretrace_tick_i,
  input  wire logic        frame_start_i,
  input  wire logic        active_i,
  input  wire logic [31:0] read_latches_i,
  input  wire logic [1:0]  read_map_select_i,
  input  wire logic        attr_toggle_i,
  input  wire logic        native_mode_i,
  input  wire logic        hsync_i,
  input  wire logic        vsync_i,
  output logic             hsync_o,
  output logic             vsync_o,
  output logic      [15:0] fb_addr_o,
  output logic      [4:0]  row_scan_o,
  output logic      [LINE_W-1:0] line_o
);

  // ---------------------------------------------------------------
  // Host register file
  // ---------------------------------------------------------------
  logic [7:0]    index_q;
  logic [7:0]    overflow_reg_q;
  logic [7:0]    max_scan_line_reg_q;
  logic [7:0]    start_address_high_q;
  logic [7:0]    start_address_low_q;
  underline_t    underline_location_reg_q;
  refresh_mode_t refresh_mode_control_q;
  logic [7:0]    line_compare_low_q;
  logic [7:0]    read_latch_view_q;
  logic [7:0]    attribute_toggle_view_q;
  logic [7:0]    rdata_q;
  logic          rvalid_q;

  logic          sel_index_w;
  logic          sel_data_w;
  logic          wr_data_w;
  logic          wr_index_w;
  logic          rd_index_w;
  logic          rd_data_w;
  logic [7:0]    rd_mux_w;
  logic [7:0]    latch_sel_w;

  assign sel_index_w = (io_addr_i == (color_sel_i ? IO_INDEX_COLR : IO_INDEX_MONO));
  assign sel_data_w  = (io_addr_i == (color_sel_i ? IO_DATA_COLR : IO_DATA_MONO));
  assign wr_data_w   = io_wr_i && sel_data_w;
  assign wr_index_w  = io_wr_i && sel_index_w;
  assign rd_index_w  = io_rd_i && sel_index_w;
  assign rd_data_w   = io_rd_i && sel_data_w;

  // Read-only views are refreshed every cycle so reads are a simple mux
  assign latch_sel_w = read_latches_i[8*read_map_select_i +: 8];

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      read_latch_view_q       <= VIEW_RESET;
      attribute_toggle_view_q <= VIEW_RESET;
    end else begin
      read_latch_view_q       <= latch_sel_w;
      attribute_toggle_view_q <= {attr_toggle_i, 7'h00};
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      index_q <= REG_RESET;
    end else if (wr_index_w) begin
      index_q <= io_wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      overflow_reg_q           <= REG_RESET;
      max_scan_line_reg_q      <= REG_RESET;
      start_address_high_q     <= REG_RESET;
      start_address_low_q      <= REG_RESET;
      underline_location_reg_q <= underline_t'(REG_RESET);
      refresh_mode_control_q   <= refresh_mode_t'(REG_RESET);
      line_compare_low_q       <= REG_RESET;
    end else if (wr_data_w) begin
      unique case (index_q)
        IDX_OVERFLOW:   overflow_reg_q       <= io_wdata_i;
        IDX_MAX_SCAN:   max_scan_line_reg_q  <= io_wdata_i;
        IDX_START_HIGH: start_address_high_q <= io_wdata_i;
        IDX_START_LOW:  start_address_low_q  <= io_wdata_i;
        IDX_UNDERLINE:  underline_location_reg_q <= underline_t'(io_wdata_i & UNDER_RSVD_MASK);
        IDX_MODE_CTRL:  refresh_mode_control_q <= refresh_mode_t'(io_wdata_i & MODE_RSVD_MASK);
        IDX_LINE_CMP:   line_compare_low_q   <= io_wdata_i;
        // Read-only views and unmapped indices drop the write
        default: ;
      endcase
    end
  end

  // Unmapped indices read as zero
  assign rd_mux_w =
    (index_q == IDX_OVERFLOW)   ? overflow_reg_q :
    (index_q == IDX_MAX_SCAN)   ? max_scan_line_reg_q :
    (index_q == IDX_START_HIGH) ? start_address_high_q :
    (index_q == IDX_START_LOW)  ? start_address_low_q :
    (index_q == IDX_UNDERLINE)  ? 8'(underline_location_reg_q) :
    (index_q == IDX_MODE_CTRL)  ? 8'(refresh_mode_control_q) & MODE_RSVD_MASK :
    (index_q == IDX_LINE_CMP)   ? line_compare_low_q :
    (index_q == IDX_LATCH_VIEW) ? read_latch_view_q :
    (index_q == IDX_TOGGLE_VW)  ? attribute_toggle_view_q :
    8'h00;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= rd_index_w || rd_data_w;
      if (rd_index_w) begin
        rdata_q <= index_q;
      end else if (rd_data_w) begin
        rdata_q <= rd_mux_w;
      end
    end
  end

  assign io_rdata_o  = rdata_q;
  assign io_rvalid_o = rvalid_q;

  // ---------------------------------------------------------------
  // Decoded controls
  // ---------------------------------------------------------------
  addr_mode_t      addr_mode_w;
  logic [1:0]      char_ratio_w;
  logic [1:0]      line_ratio_w;
  logic [LINE_W-1:0] line_cmp_w;
  logic [15:0]     start_addr_w;

  assign addr_mode_w = underline_location_reg_q.dword ? ADDR_DWORD :
                       (refresh_mode_control_q.word_byte ? ADDR_BYTE : ADDR_WORD);

  // Count-by-2 wins over count-by-4
  assign char_ratio_w = refresh_mode_control_q.count_by_2 ? DIV_BY_2 :
                        (underline_location_reg_q.count_by_4 ? DIV_BY_4 : DIV_BY_1);
  assign line_ratio_w = refresh_mode_control_q.retrace_div ? DIV_BY_2 : DIV_BY_1;

  assign line_cmp_w = LINE_W'({max_scan_line_reg_q[MSL_LINE_CMP_BIT],
                               overflow_reg_q[OVF_LINE_CMP_BIT],
                               line_compare_low_q});
  assign start_addr_w = {start_address_high_q, start_address_low_q};

  // ---------------------------------------------------------------
  // Tick division
  // ---------------------------------------------------------------
  logic adv_w;
  logic adv_active_w;
  logic vtick_w;

  // Dividers realign at frame start so every frame fetches identically
  tick_divider u_char_div (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .align_i (frame_start_i),
    .tick_i  (char_tick_i),
    .ratio_i (char_ratio_w),
    .tick_o  (adv_w)
  );

  tick_divider u_line_div (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .align_i (frame_start_i),
    .tick_i  (hretrace_tick_i),
    .ratio_i (line_ratio_w),
    .tick_o  (vtick_w)
  );

  // ---------------------------------------------------------------
  // Address, row scan and line counters
  // ---------------------------------------------------------------
  logic [15:0]       ma_q;
  logic [15:0]       ma_d;
  logic [15:0]       base_q;
  logic [15:0]       base_d;
  logic [4:0]        row_q;
  logic [4:0]        row_d;
  logic [LINE_W-1:0] line_q;
  logic [LINE_W-1:0] line_d;
  logic [LINE_W-1:0] line_next_w;
  logic              row_last_w;
  logic              split_w;

  assign line_next_w = line_q + LINE_W'(1);
  assign row_last_w  = (row_q >= max_scan_line_reg_q[4:0]);
  assign split_w     = vtick_w && active_i && (line_next_w == line_cmp_w);
  // Counter holds outside the active area; the divider keeps its phase
  assign adv_active_w = adv_w && active_i;

  // Frame start beats a line tick, which beats a character advance.
  // A row that ends keeps its final address as the next row's base.
  always_comb begin
    ma_d   = ma_q;
    base_d = base_q;
    row_d  = row_q;
    line_d = line_q;
    if (frame_start_i) begin
      ma_d   = start_addr_w;
      base_d = start_addr_w;
      row_d  = 5'h00;
      line_d = '0;
    end else if (vtick_w) begin
      line_d = line_next_w;
      if (split_w) begin
        ma_d   = 16'h0000;
        base_d = 16'h0000;
        row_d  = 5'h00;
      end else if (row_last_w) begin
        base_d = ma_q;
        row_d  = 5'h00;
      end else begin
        ma_d  = base_q;
        row_d = row_q + 5'h01;
      end
    end else if (adv_active_w) begin
      ma_d = ma_q + 16'h0001;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ma_q   <= 16'h0000;
      base_q <= 16'h0000;
      row_q  <= 5'h00;
      line_q <= '0;
    end else begin
      ma_q   <= ma_d;
      base_q <= base_d;
      row_q  <= row_d;
      line_q <= line_d;
    end
  end

  assign row_scan_o = row_q;
  assign line_o     = line_q;

  // ---------------------------------------------------------------
  // Address reorganisation and row-scan substitution
  // ---------------------------------------------------------------
  logic [15:0] reorganised_address_bit;
  logic [1:0]  row_scan_bit;
  logic [15:0] decoder_input_bit;
  logic        addr_bit14_w;
  logic        addr_bit13_w;
  logic [15:0] fb_addr_q;

  assign reorganised_address_bit =
    (addr_mode_w == ADDR_DWORD) ? {ma_q[13:0], ma_q[13], ma_q[12]} :
    (addr_mode_w == ADDR_BYTE)  ? ma_q :
    refresh_mode_control_q.addr_wrap ? {ma_q[14:0], ma_q[15]} :
    {ma_q[14:0], ma_q[13]};

  assign row_scan_bit = row_q[1:0];
  assign addr_bit14_w = refresh_mode_control_q.row_scan_sel ? reorganised_address_bit[14] :
                        row_scan_bit[1];
  assign addr_bit13_w = refresh_mode_control_q.compat ? reorganised_address_bit[13] :
                        row_scan_bit[0];

  // Substitution sits after reorganisation, just ahead of the decoder
  assign decoder_input_bit = {
    reorganised_address_bit[15],
    addr_bit14_w,
    addr_bit13_w,
    reorganised_address_bit[12:0]
  };

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fb_addr_q <= 16'h0000;
    end else begin
      fb_addr_q <= decoder_input_bit;
    end
  end

  assign fb_addr_o = fb_addr_q;

  // ---------------------------------------------------------------
  // Sync gating
  // ---------------------------------------------------------------
  logic gate_sync_w;
  logic hsync_d;
  logic vsync_d;
  logic hsync_q;
  logic vsync_q;

  // Centred modes keep their syncs whatever the enable says
  assign gate_sync_w = native_mode_i && !refresh_mode_control_q.sync_en;
  assign hsync_d     = gate_sync_w ? SYNC_INACTIVE : hsync_i;
  assign vsync_d     = gate_sync_w ? SYNC_INACTIVE : vsync_i;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hsync_q <= SYNC_INACTIVE;
      vsync_q <= SYNC_INACTIVE;
    end else begin
      hsync_q <= hsync_d;
      vsync_q <= vsync_d;
    end
  end

  assign hsync_o = hsync_q;
  assign vsync_o = vsync_q;

endmodule

// >>> dv/crtc_addr_chk.sv
// Port-level assertions for the refresh address generator
`timescale 1ns/1ps
module crtc_addr_chk
  import crtc_addr_pkg::*;
#(
  parameter int LINE_W = 10
)
(
  input wire logic              clk_i,
  input wire logic              nrst_i,
  input wire logic              color_sel_i,
  input wire logic [15:0]       io_addr_i,
  input wire logic              io_wr_i,
  input wire logic              io_rd_i,
  input wire logic [7:0]        io_wdata_i,
  input wire logic [7:0]        io_rdata_o,
  input wire logic              io_rvalid_o,
  input wire logic              char_tick_i,
  input wire logic              hretrace_tick_i,
  input wire logic              frame_start_i,
  input wire logic              attr_toggle_i,
  input wire logic              hsync_i,
  input wire logic              vsync_i,
  input wire logic              native_mode_i,
  input wire logic              hsync_o,
  input wire logic              vsync_o,
  input wire logic [15:0]       fb_addr_o,
  input wire logic [LINE_W-1:0] line_o
);
  wire [15:0] ix_w      = color_sel_i ? IO_INDEX_COLR : IO_INDEX_MONO;
  wire [15:0] dx_w      = color_sel_i ? IO_DATA_COLR : IO_DATA_MONO;
  wire        rd_any_w  = io_rd_i && (io_addr_i == ix_w || io_addr_i == dx_w);
  wire        line_ev_w = hretrace_tick_i || frame_start_i;
  wire        addr_ev_w = line_ev_w || char_tick_i || io_wr_i;
  logic [7:0] idx_q;
  logic       en_q;

  // Shadow index, so data-port reads can be told apart
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      idx_q <= REG_RESET;
    end else if (io_wr_i && io_addr_i == ix_w) begin
      idx_q <= io_wdata_i;
    end
  end

  // Shadow sync enable, reset clears it like the mode register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      en_q <= 1'b0;
    end else if (io_wr_i && io_addr_i == dx_w && idx_q == IDX_MODE_CTRL) begin
      en_q <= io_wdata_i[7];
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  sequence data_rd_s(logic [7:0] idx);
    io_rd_i && io_addr_i == dx_w && idx_q == idx;
  endsequence

  read_answer_a: assert property (rd_any_w |=> io_rvalid_o)
    else $error("Read not answered");
  read_source_a: assert property (io_rvalid_o |-> $past(rd_any_w))
    else $error("Answer without read");
  mode_rsvd_a: assert property (data_rd_s(IDX_MODE_CTRL) |=> !io_rdata_o[4])
    else $error("Reserved mode bit read as one");
  toggle_zero_a: assert property (data_rd_s(IDX_TOGGLE_VW) |=> io_rdata_o[6:0] == 7'h00)
    else $error("Toggle view low bits not zero");
  toggle_bit_a: assert property (data_rd_s(IDX_TOGGLE_VW) |=>
    io_rdata_o[TOGGLE_BIT] == $past(attr_toggle_i, 2)) else $error("Toggle bit wrong");
  hsync_gate_a: assert property (hsync_o |-> $past(hsync_i))
    else $error("Horizontal sync without cause");
  vsync_gate_a: assert property (vsync_o |-> $past(vsync_i))
    else $error("Vertical sync without cause");
  sync_held_a: assert property (native_mode_i && !en_q |=> !hsync_o && !vsync_o)
    else $error("Sync not held inactive");
  line_cause_a: assert property ($changed(line_o) |-> $past(line_ev_w) || $past(line_ev_w, 2))
    else $error("Line count moved without retrace tick");
  line_step_a: assert property ($changed(line_o) && !$past(frame_start_i) |->
    line_o == LINE_W'($past(line_o) + 1'b1)) else $error("Line count step not one");
  addr_cause_a: assert property ($changed(fb_addr_o) |-> $past(addr_ev_w) ||
    $past(addr_ev_w, 2) || $past(addr_ev_w, 3)) else $error("Address moved without cause");
endmodule

// >>> dv/fb_decoder_model.sv
// Frame buffer decoder model returning four plane latches for the fetched address
`timescale 1ns/1ps
module fb_decoder_model (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic [15:0] fb_addr_i,
  output logic      [31:0] read_latches_o
);
  // Plane k holds the low address byte xored with 11h times k
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      read_latches_o <= 32'h00000000;
    end else begin
      read_latches_o <= {4{fb_addr_i[7:0]}} ^ 32'h33221100;
    end
  end
endmodule

// >>> dv/tb_top.sv
// Self-checking bench for the refresh address generator
`timescale 1ns/1ps
module tb_top;
  import crtc_addr_pkg::*;
  localparam int LINE_W = 10;
  logic              clk_i = 1'b0, nrst_i = 1'b0, io_wr_i, io_rd_i, io_rvalid_o;
  logic              color_sel_i = 1'b1, active_i = 1'b1, native_mode_i = 1'b1;
  logic              char_tick_i, hretrace_tick_i, frame_start_i, attr_toggle_i;
  logic              hsync_i, vsync_i, hsync_o, vsync_o;
  logic [15:0]       io_addr_i, fb_addr_o, e;
  logic [7:0]        io_wdata_i, io_rdata_o, md;
  logic [31:0]       read_latches_i, rng = 32'h00007BC8;
  logic [1:0]        read_map_select_i;
  logic [4:0]        row_scan_o;
  logic [LINE_W-1:0] line_o;
  logic [7:0]        exp_q[$];
  int                err_total = 0, n_checks = 0, cyc = 0;

  vga_crtc_address_generator #(.LINE_W(LINE_W)) dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .color_sel_i(color_sel_i), .io_addr_i(io_addr_i),
    .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
    .io_rvalid_o(io_rvalid_o), .char_tick_i(char_tick_i), .hretrace_tick_i(hretrace_tick_i),
    .frame_start_i(frame_start_i), .active_i(active_i), .read_latches_i(read_latches_i),
    .read_map_select_i(read_map_select_i), .attr_toggle_i(attr_toggle_i),
    .native_mode_i(native_mode_i), .hsync_i(hsync_i), .vsync_i(vsync_i), .hsync_o(hsync_o),
    .vsync_o(vsync_o), .fb_addr_o(fb_addr_o), .row_scan_o(row_scan_o), .line_o(line_o));
  fb_decoder_model fbm (.clk_i(clk_i), .nrst_i(nrst_i), .fb_addr_i(fb_addr_o),
    .read_latches_o(read_latches_i));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Row scan is zero after frame start, so substituted bits read as zero
  function automatic logic [15:0] reorg(input logic [15:0] c, input logic [7:0] m, input logic dw);
    logic [15:0] r;
    r = dw ? {c[13:0], c[13], c[12]} : m[6] ? c : m[5] ? {c[14:0], c[15]} : {c[14:0], c[13]};
    if (!m[1]) r[14] = 1'b0;
    if (!m[0]) r[13] = 1'b0;
    return r;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_i);
    io_addr_i = a;
    io_wdata_i = d;
    io_wr_i = 1'b1;
    @(negedge clk_i);
    io_wr_i = 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    io_wr(color_sel_i ? IO_INDEX_COLR : IO_INDEX_MONO, idx);
    io_wr(color_sel_i ? IO_DATA_COLR : IO_DATA_MONO, d);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] x);
    io_wr(color_sel_i ? IO_INDEX_COLR : IO_INDEX_MONO, idx);
    exp_q.push_back(x);
    io_addr_i = color_sel_i ? IO_DATA_COLR : IO_DATA_MONO;
    io_rd_i = 1'b1;
    @(negedge clk_i);
    io_rd_i = 1'b0;
  endtask
  task automatic set_start(input logic [15:0] s);
    wr(IDX_START_HIGH, s[15:8]);
    wr(IDX_START_LOW, s[7:0]);
  endtask
  // Pattern bits: frame start, retrace tick, character tick
  task automatic pulse(input int n, input logic [2:0] w);
    repeat (n) begin
      @(negedge clk_i);
      {frame_start_i, hretrace_tick_i, char_tick_i} = w;
      @(negedge clk_i);
      {frame_start_i, hretrace_tick_i, char_tick_i} = 3'h0;
    end
    repeat (4) @(negedge clk_i);
  endtask

  // Read results are matched oldest first; cycle ceiling cuts a hang short
  always @(negedge clk_i) begin
    cyc++;
    if (io_rvalid_o === 1'b1) begin
      chk({8'h00, io_rdata_o}, exp_q.size() ? {8'h00, exp_q.pop_front()} : 16'hFFFF);
    end
    if (cyc == 20000) begin
      err_total++;
      end_of_test();
    end
  end

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    {io_addr_i, io_wdata_i, io_wr_i, io_rd_i} = 26'h0000000;
    {char_tick_i, hretrace_tick_i, frame_start_i} = 3'h0;
    {hsync_i, vsync_i, attr_toggle_i, read_map_select_i} = 5'h00;
    repeat (2) @(negedge clk_i);
    nrst_i = 1'b1;
    rd(IDX_LATCH_VIEW, VIEW_RESET);
    rd(IDX_TOGGLE_VW, VIEW_RESET);
    wr(IDX_LATCH_VIEW, 8'hFF);
    rd(IDX_LATCH_VIEW, VIEW_RESET);
    rd(8'h30, 8'h00);
    rng = lfsr(rng);
    wr(IDX_MODE_CTRL, rng[7:0]);
    rd(IDX_MODE_CTRL, rng[7:0] & MODE_RSVD_MASK);
    attr_toggle_i = 1'b1;
    rd(IDX_TOGGLE_VW, 8'h80);
    $display("Register test done");
    for (int m = 0; m < 16; m++) begin
      rng = lfsr(rng);
      md = {1'b1, m[3] == m[2], m[2], 3'h0, m[1:0]};
      wr(IDX_UNDERLINE, {1'b0, m[3] & m[2], 6'h00});
      wr(IDX_MODE_CTRL, md);
      set_start(rng[15:0]);
      pulse(1, 3'h4);
      chk(fb_addr_o, reorg(rng[15:0], md, m[3] & m[2]));
    end
    $display("Reorganisation test done");
    for (int k = 0; k < 4; k++) begin
      rng = lfsr(rng);
      wr(IDX_UNDERLINE, {2'h0, k[1], 5'h00});
      wr(IDX_MODE_CTRL, {4'hC, k[0], 3'h3});
      set_start(rng[15:0]);
      pulse(1, 3'h4);
      pulse(8, 3'h1);
      e = rng[15:0] + ((k == 2) ? 16'h0002 : (k == 0) ? 16'h0008 : 16'h0004);
      chk(fb_addr_o, e);
      read_map_select_i = k[1:0];
      rd(IDX_LATCH_VIEW, e[7:0] ^ (8'h11 * k[7:0]));
    end
    $display("Count interval test done");
    {hsync_i, vsync_i} = 2'h3;
    for (int k = 0; k < 2; k++) begin
      wr(IDX_MODE_CTRL, {k[0], 7'h43});
      repeat (3) @(negedge clk_i);
      chk({14'h0000, hsync_o, vsync_o}, {14'h0000, {2{k[0]}}});
    end
    $display("Sync gating test done");
    // Compare point 302h needs all three register pieces in place
    wr(IDX_MODE_CTRL, 8'hC3);
    wr(IDX_MAX_SCAN, 8'h40);
    wr(IDX_OVERFLOW, 8'h10);
    wr(IDX_LINE_CMP, 8'h02);
    rng = lfsr(rng);
    set_start(rng[15:0] | 16'h0001);
    pulse(1, 3'h4);
    pulse(769, 3'h2);
    chk(fb_addr_o, rng[15:0] | 16'h0001);
    pulse(1, 3'h2);
    chk(fb_addr_o, 16'h0000);
    chk({6'h00, line_o}, 16'h0302);
    wr(IDX_MODE_CTRL, 8'hC7);
    pulse(1, 3'h4);
    pulse(8, 3'h2);
    chk({6'h00, line_o}, 16'h0004);
    $display("Split and retrace test done");
    // Row scan 3 lands in address bits 14 and 13
    wr(IDX_MAX_SCAN, 8'h03);
    wr(IDX_MODE_CTRL, 8'h40);
    rng = lfsr(rng);
    set_start(rng[15:0]);
    pulse(1, 3'h4);
    pulse(3, 3'h2);
    e = {rng[15], 2'h3, rng[12:0]};
    chk(fb_addr_o, e);
    chk({11'h000, row_scan_o}, 16'h0003);
    active_i = 1'b0;
    pulse(4, 3'h1);
    chk(fb_addr_o, e);
    active_i = 1'b1;
    native_mode_i = 1'b0;
    repeat (2) @(negedge clk_i);
    chk({14'h0000, hsync_o, vsync_o}, 16'h0003);
    color_sel_i = 1'b0;
    rd(IDX_MAX_SCAN, 8'h03);
    $display("Row scan and port test done");
    repeat (4) @(negedge clk_i);
    end_of_test();
  end
endmodule

bind vga_crtc_address_generator crtc_addr_chk #(.LINE_W(LINE_W)) chk (
  .clk_i(clk_i), .nrst_i(nrst_i), .color_sel_i(color_sel_i), .io_addr_i(io_addr_i),
  .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
  .io_rvalid_o(io_rvalid_o), .char_tick_i(char_tick_i), .hretrace_tick_i(hretrace_tick_i),
  .frame_start_i(frame_start_i), .attr_toggle_i(attr_toggle_i), .hsync_i(hsync_i),
  .vsync_i(vsync_i), .native_mode_i(native_mode_i), .hsync_o(hsync_o), .vsync_o(vsync_o),
  .fb_addr_o(fb_addr_o),
  .line_o(line_o));
